/* File: hdl/pmm_map.sv */
`timescale 1ns/1ns
`default_nettype none
module pmm_map (
  input wire logic CLK_SYS, // system clock, 250 MHz
  input wire logic SRST, // synchronous reset, active high
  input wire logic EXT_ACCESS_PIN, // external-access pin, asynchronous
  input wire logic BOOT_LOADER, // boot choice, asynchronous strap
  input wire logic [15:0] MAIN_SIZE, // last main-bank byte address, static
  input wire logic [15:0] DATA_BASE, // data flash start, static
  input wire pmm_pkg::pmm_fetch_t FETCH, // cpu fetch or table read
  input wire logic IRQ_ACCEPT, // interrupt accepted, one cycle
  input wire logic [pmm_pkg::SRC_W-1:0] IRQ_SRC, // accepted source number
  input wire pmm_pkg::pmm_flash_req_t PROG_REQ, // flash op from programmer
  input wire pmm_pkg::pmm_flash_req_t ISP_REQ, // flash op from isp path
  output pmm_pkg::pmm_mem_req_t MEM_REQ, // mapped fetch request
  output logic [15:0] PC_LOAD, // new program counter value
  output logic PC_LOAD_VALID, // pc load strobe
  output pmm_pkg::pmm_flash_req_t FLASH_CMD, // command to flash arrays
  output logic FLASH_REJECT, // isp op refused, one cycle
  output logic BOOTED_LOADER // latched boot bank
);
  import pmm_pkg::*;

  function automatic logic [15:0] vec_addr(input logic [SRC_W-1:0] src);
    vec_addr = VEC_BASE + {8'h00, 4'h0, src} * (16'h0001 << VEC_SHIFT);
  endfunction

  function automatic logic valid_target(input pmm_flash_req_t r);
    logic [15:0] lim;
    lim = 16'h0000;
    unique case (r.bank)
      PMM_BANK_LDR: lim = LDR_SIZE - 16'h0001;
      PMM_BANK_CFG: lim = PAGE_BYTES - 16'h0001;
      PMM_BANK_MAIN: lim = MAIN_SIZE;
      PMM_BANK_DATA: lim = 16'hFFFF;
    endcase
    valid_target = (r.addr <= lim) && (r.op != PMM_OP_NONE);
  endfunction

  logic ea_s1_ff, ea_s2_ff, bl_s1_ff, bl_s2_ff;
  logic ext_all_ff, ldr_ff, rst_d_ff;

  // two-flop synchronisers for pins
  always_ff @(posedge CLK_SYS) begin
    ea_s1_ff <= EXT_ACCESS_PIN;
    ea_s2_ff <= ea_s1_ff;
    bl_s1_ff <= BOOT_LOADER;
    bl_s2_ff <= bl_s1_ff;
  end

  // latch pin and bank at reset release
  always_ff @(posedge CLK_SYS) begin
    rst_d_ff <= SRST;
    if (rst_d_ff && !SRST) begin
      ext_all_ff <= !ea_s2_ff;
      ldr_ff <= bl_s2_ff;
    end
    if (SRST) begin
      rst_d_ff <= 1'b1;
    end
  end
  assign BOOTED_LOADER = ldr_ff;

  logic [15:0] nxt_pc;
  logic nxt_pc_v;
  // reset vector and interrupt vectors
  always_comb begin
    nxt_pc = RESET_VEC;
    nxt_pc_v = 1'b0;
    if (rst_d_ff && !SRST) begin
      nxt_pc_v = 1'b1;
    end else if (IRQ_ACCEPT) begin
      nxt_pc = vec_addr(IRQ_SRC);
      nxt_pc_v = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      PC_LOAD <= RESET_VEC;
      PC_LOAD_VALID <= 1'b0;
    end else begin
      PC_LOAD <= nxt_pc;
      PC_LOAD_VALID <= nxt_pc_v;
    end
  end

  pmm_mem_req_t nxt_mem;
  // fetch mapping; vector slots are plain storage
  always_comb begin
    nxt_mem = '0;
    nxt_mem.valid = FETCH.valid;
    nxt_mem.table_rd = FETCH.table_rd;
    nxt_mem.addr = FETCH.addr;
    nxt_mem.bank = ldr_ff ? PMM_BANK_LDR : PMM_BANK_MAIN;
    if (ext_all_ff) begin
      nxt_mem.ext = 1'b1;
    end else if (ldr_ff) begin
      nxt_mem.ext = FETCH.addr >= LDR_SIZE;
    end else begin
      nxt_mem.ext = FETCH.addr > MAIN_SIZE;
      if (FETCH.addr >= DATA_BASE && FETCH.table_rd) begin
        nxt_mem.bank = PMM_BANK_DATA;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      MEM_REQ <= '0;
    end else begin
      MEM_REQ <= nxt_mem;
    end
  end

  pmm_flash_req_t nxt_cmd;
  logic nxt_rej;
  // programmer first, then isp; isp barred on external code
  always_comb begin
    nxt_cmd = '0;
    nxt_rej = 1'b0;
    if (PROG_REQ.valid && valid_target(PROG_REQ)) begin
      nxt_cmd = PROG_REQ;
    end else if (ISP_REQ.valid) begin
      if (!ext_all_ff && valid_target(ISP_REQ)) begin
        nxt_cmd = ISP_REQ;
      end else begin
        nxt_rej = 1'b1;
      end
    end
    if (nxt_cmd.op == PMM_OP_ERASE) begin
      nxt_cmd.addr = {nxt_cmd.addr[15:PAGE_SHIFT], 8'h00};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      FLASH_CMD <= '0;
      FLASH_REJECT <= 1'b0;
    end else begin
      FLASH_CMD <= nxt_cmd;
      FLASH_REJECT <= nxt_rej;
    end
  end

  a_reset_vector: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $fell(rst_d_ff) |-> PC_LOAD_VALID && PC_LOAD == 16'h0000)
    else $error("reset vector not loaded");
  a_irq_vector: assert property (@(posedge CLK_SYS) disable iff (SRST)
    IRQ_ACCEPT && !rst_d_ff |=> PC_LOAD_VALID &&
    PC_LOAD == 16'h0003 + {$past(IRQ_SRC), 3'b000})
    else $error("wrong interrupt vector");
  a_irq_load: assert property (@(posedge CLK_SYS) disable iff (SRST)
    PC_LOAD_VALID |-> $past(IRQ_ACCEPT) || $past(rst_d_ff))
    else $error("spurious pc load");
  a_bank_held: assert property (@(posedge CLK_SYS) disable iff (SRST)
    !rst_d_ff |=> $stable(ldr_ff) && $stable(ext_all_ff))
    else $error("boot latch changed");
  a_ext_all: assert property (@(posedge CLK_SYS) disable iff (SRST)
    ext_all_ff && FETCH.valid |=> MEM_REQ.ext)
    else $error("fetch not external");
  a_ldr_bank: assert property (@(posedge CLK_SYS) disable iff (SRST)
    ldr_ff && FETCH.valid |=> MEM_REQ.bank == PMM_BANK_LDR)
    else $error("loader boot not rebased");
  a_main_limit: assert property (@(posedge CLK_SYS) disable iff (SRST)
    !ext_all_ff && !ldr_ff && FETCH.valid && FETCH.addr > MAIN_SIZE
    |=> MEM_REQ.ext)
    else $error("overflow not external");
  a_erase_page: assert property (@(posedge CLK_SYS) disable iff (SRST)
    FLASH_CMD.op == PMM_OP_ERASE |-> FLASH_CMD.addr[7:0] == 8'h00)
    else $error("erase not page aligned");
  a_isp_ext_block: assert property (@(posedge CLK_SYS) disable iff (SRST)
    ext_all_ff && ISP_REQ.valid && !PROG_REQ.valid |=> FLASH_REJECT)
    else $error("isp not refused");
  c_irq: cover property (@(posedge CLK_SYS) IRQ_ACCEPT ##1 PC_LOAD_VALID);
  c_loader: cover property (@(posedge CLK_SYS) ldr_ff && FETCH.valid);
  c_isp: cover property (@(posedge CLK_SYS) ISP_REQ.valid ##1 FLASH_CMD.valid);
endmodule
`default_nettype wire

/* File: hdl/pmm_pkg.sv */
package pmm_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] RESET_VEC = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;
  localparam int SRC_W = 4;
  localparam logic [15:0] PAGE_BYTES = 16'h0100;
  localparam int PAGE_SHIFT = 8;
  localparam logic [16:0] MAIN_MAX = 17'h10000;
  localparam logic [15:0] LDR_SIZE = 16'h0A00;
  localparam logic [15:0] MAIN_SIZE_DEF = 16'hFFFF;
  localparam logic [15:0] DATA_BASE_DEF = 16'hF000;
  typedef enum logic [1:0] {
    PMM_BANK_MAIN = 2'b00,
    PMM_BANK_DATA = 2'b01,
    PMM_BANK_LDR = 2'b10,
    PMM_BANK_CFG = 2'b11
  } pmm_bank_t;
  typedef enum logic [1:0] {
    PMM_OP_READ = 2'b00,
    PMM_OP_PROG = 2'b01,
    PMM_OP_ERASE = 2'b10,
    PMM_OP_NONE = 2'b11
  } pmm_op_t;
  typedef enum logic [1:0] {
    PMM_TGT_INT = 2'b00,
    PMM_TGT_EXT = 2'b01
  } pmm_tgt_t;
  typedef struct packed {
    logic valid;
    logic table_rd;
    logic [15:0] addr;
  } pmm_fetch_t;
  typedef struct packed {
    logic valid;
    pmm_op_t op;
    pmm_bank_t bank;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pmm_flash_req_t;
  typedef struct packed {
    logic valid;
    logic ext;
    pmm_bank_t bank;
    logic [15:0] addr;
    logic table_rd;
  } pmm_mem_req_t;
endpackage

/* File: verification/pmm_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pmm_cpu_model (
  input wire logic clk, // system clock
  output pmm_pkg::pmm_fetch_t fetch, // fetch or table read request
  output logic irq_accept, // interrupt accepted pulse
  output logic [pmm_pkg::SRC_W-1:0] irq_src // accepted source number
);
  import pmm_pkg::*;
  // idle port at time zero
  initial begin
    fetch = '0;
    irq_accept = 1'b0;
    irq_src = '0;
  end
  // one fetch cycle, released at the next edge
  task automatic fetch_at(input logic tr, input logic [15:0] a);
    @(posedge clk);
    fetch <= '{valid: 1'b1, table_rd: tr, addr: a};
    @(posedge clk);
    fetch <= '0;
  endtask
  // one accepted interrupt, source held while the strobe is up
  task automatic irq(input logic [SRC_W-1:0] s);
    @(posedge clk);
    irq_accept <= 1'b1;
    irq_src <= s;
    @(posedge clk);
    irq_accept <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verification/pmm_map_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module pmm_map_tb;
  import pmm_pkg::*;
  logic CLK_SYS, SRST, EXT_ACCESS_PIN, BOOT_LOADER;
  pmm_fetch_t FETCH;
  logic IRQ_ACCEPT;
  logic [SRC_W-1:0] IRQ_SRC;
  pmm_flash_req_t PROG_REQ, ISP_REQ, FLASH_CMD;
  pmm_mem_req_t MEM_REQ;
  logic [15:0] PC_LOAD;
  logic PC_LOAD_VALID, FLASH_REJECT, BOOTED_LOADER;
  int n_fail = 0;
  int checked = 0;
  pmm_map i_pmm_map (.CLK_SYS(CLK_SYS), .SRST(SRST),
    .EXT_ACCESS_PIN(EXT_ACCESS_PIN), .BOOT_LOADER(BOOT_LOADER),
    .MAIN_SIZE(16'h7FFF), .DATA_BASE(16'h7000), .FETCH(FETCH),
    .IRQ_ACCEPT(IRQ_ACCEPT), .IRQ_SRC(IRQ_SRC), .PROG_REQ(PROG_REQ),
    .ISP_REQ(ISP_REQ), .MEM_REQ(MEM_REQ), .PC_LOAD(PC_LOAD),
    .PC_LOAD_VALID(PC_LOAD_VALID), .FLASH_CMD(FLASH_CMD),
    .FLASH_REJECT(FLASH_REJECT), .BOOTED_LOADER(BOOTED_LOADER));
  pmm_cpu_model i_pmm_cpu_model (.clk(CLK_SYS), .fetch(FETCH),
    .irq_accept(IRQ_ACCEPT), .irq_src(IRQ_SRC));
  // clock and time-zero inputs
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    SRST = 1'b1;
    EXT_ACCESS_PIN = 1'b1;
    BOOT_LOADER = 1'b0;
    PROG_REQ = '0;
    ISP_REQ = '0;
  end
  // single compare for every kind of result, zero-extended
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // reset with strap levels, then wait for the reset vector load
  task automatic do_reset(input logic pin, input logic boot);
    int k;
    @(posedge CLK_SYS);
    SRST <= 1'b1;
    EXT_ACCESS_PIN <= pin;
    BOOT_LOADER <= boot;
    repeat (6) @(posedge CLK_SYS);
    SRST <= 1'b0;
    // look just after each edge so the one-cycle strobe is seen settled
    for (k = 0; k < 8 && PC_LOAD_VALID !== 1'b1; k++) begin
      @(posedge CLK_SYS);
      #1;
    end
    chk("pc_valid_reset", 1'b1, PC_LOAD_VALID);
    chk("pc_load_reset", 16'h0000, PC_LOAD);
    chk("booted_loader", boot, BOOTED_LOADER);
    @(posedge CLK_SYS);
    BOOT_LOADER <= ~boot;
  endtask
  // fetch and compare the mapped request, or only its external flag
  task automatic mem(input logic tr, input logic [15:0] a,
                     input logic [31:0] e, input logic ext_only);
    i_pmm_cpu_model.fetch_at(tr, a);
    #1;
    if (ext_only)
      chk("mem_ext", 1'b1, MEM_REQ.ext);
    else
      chk("mem_req", e, MEM_REQ);
  endtask
  // flash request on either path, compare command or refusal
  task automatic fl(input pmm_flash_req_t p, i, input logic [28:0] e);
    @(posedge CLK_SYS);
    PROG_REQ <= p;
    ISP_REQ <= i;
    @(posedge CLK_SYS);
    PROG_REQ <= '0;
    ISP_REQ <= '0;
    #1 chk("flash_reject", e == '0, FLASH_REJECT);
    if (e != '0)
      chk("flash_cmd", e, FLASH_CMD);
  endtask
  task automatic t_main_boot;
    do_reset(1'b1, 1'b0);
    mem(1'b0, 16'h0003, {2'b10, PMM_BANK_MAIN, 16'h0003, 1'b0}, 0);
    mem(1'b0, 16'h8000, '0, 1);
    mem(1'b1, 16'h7100, {2'b10, PMM_BANK_DATA, 16'h7100, 1'b1}, 0);
    mem(1'b1, 16'h0100, {2'b10, PMM_BANK_MAIN, 16'h0100, 1'b1}, 0);
    chk("booted_held", 1'b0, BOOTED_LOADER);
  endtask
  task automatic t_irq;
    for (int s = 0; s < 4; s++) begin
      i_pmm_cpu_model.irq(s[SRC_W-1:0]);
      #1 chk("pc_valid", 1'b1, PC_LOAD_VALID);
      chk("pc_vector", 16'h0003 + 16'(8 * s), PC_LOAD);
    end
  endtask
  task automatic t_flash;
    pmm_op_t op;
    for (int o = 0; o < 3; o++) begin
      op = pmm_op_t'(o);
      fl('0, {1'b1, op, PMM_BANK_MAIN, 16'h1234, 8'h5A}, {1'b1, op,
         PMM_BANK_MAIN, (op == PMM_OP_ERASE) ? 16'h1200 : 16'h1234,
         8'h5A});
    end
    fl('0, {1'b1, PMM_OP_PROG, PMM_BANK_LDR, 16'h09FF, 8'hA5},
       {1'b1, PMM_OP_PROG, PMM_BANK_LDR, 16'h09FF, 8'hA5});
    fl('0, {1'b1, PMM_OP_PROG, PMM_BANK_LDR, 16'h0A00, 8'hA5}, '0);
    fl({1'b1, PMM_OP_READ, PMM_BANK_CFG, 16'h0010, 8'h00},
       {1'b1, PMM_OP_PROG, PMM_BANK_MAIN, 16'h0001, 8'h11},
       {1'b1, PMM_OP_READ, PMM_BANK_CFG, 16'h0010, 8'h00});
  endtask
  task automatic t_loader_boot;
    do_reset(1'b1, 1'b1);
    mem(1'b0, 16'h0000, {2'b10, PMM_BANK_LDR, 16'h0000, 1'b0}, 0);
    mem(1'b0, 16'h0A00, '0, 1);
    fl('0, {1'b1, PMM_OP_ERASE, PMM_BANK_MAIN, 16'h2345, 8'h00},
       {1'b1, PMM_OP_ERASE, PMM_BANK_MAIN, 16'h2300, 8'h00});
    chk("booted_held", 1'b1, BOOTED_LOADER);
  endtask
  task automatic t_pin_low;
    do_reset(1'b0, 1'b0);
    EXT_ACCESS_PIN <= 1'b1;
    mem(1'b0, 16'h0100, '0, 1);
    fl('0, {1'b1, PMM_OP_READ, PMM_BANK_MAIN, 16'h0100, 8'h00}, '0);
  endtask
  // main sequence
  initial begin
    t_main_boot();
    t_irq();
    t_flash();
    t_loader_boot();
    t_pin_low();
    report_and_stop();
  end
  // watchdog, well beyond the fewer than one hundred cycles the tests need
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
